//--- i2c_slv_regs.svh
// register offsets, field positions and reset values of the i2c slave status block
// assumes an axi4-lite slave with 32-bit data, one aligned word per register
`ifndef I2C_SLV_REGS_SVH
`define I2C_SLV_REGS_SVH
`define REG_STATUS_CONTROL 8'h00
`define REG_SLAVE_ADDR     8'h04
`define REG_DATA           8'h08
`define REG_IRQ_STATUS     8'h0C
`define REG_IRQ_CLEAR      8'h10
`define REG_IRQ_ENABLE     8'h14
`define CTL_RESET          8'h81
`define CTL_SW_MASK        8'h1E
`define IRQ_ADDR_HIT       0
`define IRQ_BYTE_DONE      1
`define IRQ_START          2
`define IRQ_STOP           3
`define IRQ_W              4
`define BITS_PER_BYTE      4'h8
`define RESP_OKAY          2'b00
`define RESP_SLVERR        2'b10
`endif

//--- i2c_slv_pkg.sv
// types shared by the i2c slave status block
// assumes i2c_slv_regs.svh supplies the numeric constants
package i2c_slv_pkg;
   // status/control byte, bit 7 down to bit 0
   typedef struct packed {
      logic byte_done_flag;
      logic address_hit_flag;
      logic line_occupied_flag;
      logic direction_select;
      logic ack_output_level;
      logic master_direction_flag;
      logic address_wake_enable;
      logic received_ack_flag;
   } ctl_t;
   typedef enum logic [1:0] {ST_IDLE, ST_ADDR, ST_DATA, ST_SKIP} link_st_t;
endpackage

//--- i2c_slv_status.sv
// i2c slave byte engine with its status/control byte behind axi4-lite
// assumes open-drain sda/scl resolved outside; scl and sda are asynchronous pins
//
// Our own choices: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "i2c_slv_regs.svh"
module i2c_slv_status import i2c_slv_pkg::*; (
   input  wire logic        i_sys_clk,
   input  wire logic        i_reset_n,
   input  wire logic        i_scl,
   input  wire logic        i_sda,
   output logic             o_sda,
   output logic             o_sda_oe_n,
   output logic             o_irq,
   output logic             o_wake,
   input  wire logic [7:0]  i_awaddr,
   input  wire logic        i_awvalid,
   output logic             o_awready,
   input  wire logic [31:0] i_wdata,
   input  wire logic [3:0]  i_wstrb,
   input  wire logic        i_wvalid,
   output logic             o_wready,
   output logic [1:0]       o_bresp,
   output logic             o_bvalid,
   input  wire logic        i_bready,
   input  wire logic [7:0]  i_araddr,
   input  wire logic        i_arvalid,
   output logic             o_arready,
   output logic [31:0]      o_rdata,
   output logic [1:0]       o_rresp,
   output logic             o_rvalid,
   input  wire logic        i_rready
);
   ctl_t                 ctl_q;
   link_st_t             st_q;
   logic [2:0]           scl_sy_q, sda_sy_q;
   logic                 scl_q, sda_q;
   logic                 scl_rise, scl_fall, start, stop;
   logic [3:0]           cnt_q;
   logic                 in_ack_q, drv_q;
   logic [7:0]           sh_q, rx_q, tx_q;
   logic [6:0]           own_addr_q;
   logic [`IRQ_W-1:0]    ist_q, ien_q, ev, clr;
   logic                 aw_full_q, w_full_q;
   logic [7:0]           awaddr_q, wa;
   logic [31:0]          wdata_q, wd;
   logic [3:0]           wstrb_q, ws;
   logic                 do_wr, sw_wr_ctl;

   ////////////////////////////////////////////////////////////////////////////
   // pin synchronisers: a level counts once stages two and three agree
   always_ff @(posedge i_sys_clk) begin
      if (!i_reset_n) begin
         scl_sy_q <= 3'h7;
         sda_sy_q <= 3'h7;
         scl_q    <= 1'b1;
         sda_q    <= 1'b1;
      end else begin
         scl_sy_q <= {scl_sy_q[1:0], i_scl};
         sda_sy_q <= {sda_sy_q[1:0], i_sda};
         if (scl_sy_q[1] == scl_sy_q[2]) scl_q <= scl_sy_q[2];
         if (sda_sy_q[1] == sda_sy_q[2]) sda_q <= sda_sy_q[2];
      end
   end

   // edges of the filtered levels; sda edges with scl high are start/stop
   assign scl_rise = (scl_sy_q[1] == scl_sy_q[2]) && scl_sy_q[2] && !scl_q;
   assign scl_fall = (scl_sy_q[1] == scl_sy_q[2]) && !scl_sy_q[2] && scl_q;
   assign start    = (sda_sy_q[1] == sda_sy_q[2]) && !sda_sy_q[2] && sda_q && scl_q;
   assign stop     = (sda_sy_q[1] == sda_sy_q[2]) && sda_sy_q[2] && !sda_q && scl_q;

   ////////////////////////////////////////////////////////////////////////////
   // byte engine: shift on scl rise, change sda only after scl fall
   always_ff @(posedge i_sys_clk) begin
      if (!i_reset_n) begin
         st_q     <= ST_IDLE;
         cnt_q    <= 4'h0;
         in_ack_q <= 1'b0;
         drv_q    <= 1'b0;
         sh_q     <= 8'h00;
         rx_q     <= 8'h00;
      end else if (start) begin
         st_q     <= ST_ADDR;
         cnt_q    <= 4'h0;
         in_ack_q <= 1'b0;
         drv_q    <= 1'b0;
      end else if (stop) begin
         st_q     <= ST_IDLE;
         in_ack_q <= 1'b0;
         drv_q    <= 1'b0;
      end else if (st_q == ST_ADDR || st_q == ST_DATA) begin
         if (scl_rise && cnt_q < `BITS_PER_BYTE) begin
            sh_q  <= {sh_q[6:0], sda_q};
            cnt_q <= cnt_q + 4'h1;
         end else if (scl_fall && cnt_q == `BITS_PER_BYTE && !in_ack_q) begin
            in_ack_q <= 1'b1;
            if (st_q == ST_ADDR) begin
               // unmatched address: stay off the bus until the next start
               if (sh_q[7:1] == own_addr_q) drv_q <= 1'b1;
               else st_q <= ST_SKIP;
            end else if (!ctl_q.direction_select) begin
               rx_q  <= sh_q;
               drv_q <= !ctl_q.ack_output_level;
            end else begin
               drv_q <= 1'b0; // master owns the ack slot
            end
         end else if (scl_fall && in_ack_q) begin
            in_ack_q <= 1'b0;
            cnt_q    <= 4'h0;
            if (st_q == ST_ADDR) st_q <= ST_DATA;
            if (ctl_q.direction_select && (st_q == ST_ADDR || !ctl_q.received_ack_flag)) begin
               sh_q  <= tx_q;
               drv_q <= !tx_q[7];
            end else begin
               drv_q <= 1'b0;
               if (st_q == ST_DATA && ctl_q.direction_select) st_q <= ST_SKIP;
            end
         end else if (scl_fall && ctl_q.direction_select && st_q == ST_DATA) begin
            drv_q <= !sh_q[7];
         end
      end else begin
         drv_q <= 1'b0;
      end
   end

   // open drain: only ever pull low, enable is active low
   assign o_sda      = 1'b0;
   assign o_sda_oe_n = !drv_q;

   ////////////////////////////////////////////////////////////////////////////
   // status flags; hardware updates win over software writes of the same bit
   logic addr_last, addr_match, ninth_tx;
   assign addr_last  = scl_rise && st_q == ST_ADDR && cnt_q == 4'h7;
   assign addr_match = sh_q[6:0] == own_addr_q;
   assign ninth_tx   = scl_rise && st_q == ST_DATA && ctl_q.direction_select && in_ack_q;

   always_ff @(posedge i_sys_clk) begin
      if (!i_reset_n) begin
         ctl_q <= ctl_t'(`CTL_RESET);
      end else begin
         if (sw_wr_ctl) begin
            ctl_q.direction_select      <= wd[4];
            ctl_q.ack_output_level      <= wd[3];
            ctl_q.master_direction_flag <= wd[2];
            ctl_q.address_wake_enable   <= wd[1];
         end
         if (start) ctl_q.line_occupied_flag <= 1'b1;
         else if (stop) ctl_q.line_occupied_flag <= 1'b0;
         if (start) ctl_q.address_hit_flag <= 1'b0;
         else if (addr_last) ctl_q.address_hit_flag <= addr_match;
         if (addr_last) ctl_q.master_direction_flag <= sda_q;
         if ((st_q == ST_ADDR || st_q == ST_DATA) && scl_rise && cnt_q == 4'h0 && !in_ack_q)
            ctl_q.byte_done_flag <= 1'b0;
         else if ((st_q == ST_ADDR || st_q == ST_DATA) && scl_rise && cnt_q == 4'h7)
            ctl_q.byte_done_flag <= 1'b1;
         if (ninth_tx) ctl_q.received_ack_flag <= sda_q;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // sticky interrupt status; a new event beats a clear in the same cycle
   always_comb begin
      ev                 = '0;
      ev[`IRQ_ADDR_HIT]  = addr_last && addr_match;
      ev[`IRQ_BYTE_DONE] = (st_q == ST_DATA) && scl_rise && cnt_q == 4'h7;
      ev[`IRQ_START]     = start;
      ev[`IRQ_STOP]      = stop;
   end

   always_ff @(posedge i_sys_clk) begin
      if (!i_reset_n) ist_q <= '0;
      else ist_q <= (ist_q & ~clr) | ev;
   end

   assign o_irq  = |(ist_q & ien_q);
   assign o_wake = ctl_q.address_hit_flag && ctl_q.address_wake_enable;

   ////////////////////////////////////////////////////////////////////////////
   // axi4-lite write: address and data taken in either order, one at a time
   assign o_awready = !aw_full_q && !o_bvalid;
   assign o_wready  = !w_full_q && !o_bvalid;
   assign wa        = aw_full_q ? awaddr_q : i_awaddr;
   assign wd        = w_full_q ? wdata_q : i_wdata;
   assign ws        = w_full_q ? wstrb_q : i_wstrb;
   assign do_wr     = (aw_full_q || (i_awvalid && o_awready)) && (w_full_q || (i_wvalid && o_wready));
   assign sw_wr_ctl = do_wr && ws[0] && wa == `REG_STATUS_CONTROL;
   assign clr       = (do_wr && ws[0] && wa == `REG_IRQ_CLEAR) ? wd[`IRQ_W-1:0] : '0;

   always_ff @(posedge i_sys_clk) begin
      if (!i_reset_n) begin
         aw_full_q <= 1'b0;
         w_full_q  <= 1'b0;
         awaddr_q  <= 8'h00;
         wdata_q   <= 32'h0000_0000;
         wstrb_q   <= 4'h0;
         o_bvalid  <= 1'b0;
         o_bresp   <= `RESP_OKAY;
      end else if (do_wr) begin
         aw_full_q <= 1'b0;
         w_full_q  <= 1'b0;
         o_bvalid  <= 1'b1;
         o_bresp   <= (wa > `REG_IRQ_ENABLE || wa[1:0] != 2'b00) ? `RESP_SLVERR : `RESP_OKAY;
      end else begin
         if (i_awvalid && o_awready) begin
            aw_full_q <= 1'b1;
            awaddr_q  <= i_awaddr;
         end
         if (i_wvalid && o_wready) begin
            w_full_q <= 1'b1;
            wdata_q  <= i_wdata;
            wstrb_q  <= i_wstrb;
         end
         if (o_bvalid && i_bready) o_bvalid <= 1'b0;
      end
   end

   // software-owned registers
   always_ff @(posedge i_sys_clk) begin
      if (!i_reset_n) begin
         own_addr_q <= 7'h00;
         tx_q       <= 8'h00;
         ien_q      <= '0;
      end else if (do_wr && ws[0]) begin
         if (wa == `REG_SLAVE_ADDR) own_addr_q <= wd[7:1];
         if (wa == `REG_DATA) tx_q <= wd[7:0];
         if (wa == `REG_IRQ_ENABLE) ien_q <= wd[`IRQ_W-1:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // axi4-lite read: one beat, answer the cycle after the address is taken
   assign o_arready = !o_rvalid;

   always_ff @(posedge i_sys_clk) begin
      if (!i_reset_n) begin
         o_rvalid <= 1'b0;
         o_rdata  <= 32'h0000_0000;
         o_rresp  <= `RESP_OKAY;
      end else if (i_arvalid && o_arready) begin
         o_rvalid <= 1'b1;
         o_rresp  <= `RESP_OKAY;
         case (i_araddr)
            `REG_STATUS_CONTROL: o_rdata <= {24'h00_0000, ctl_q};
            `REG_SLAVE_ADDR:     o_rdata <= {24'h00_0000, own_addr_q, 1'b0};
            `REG_DATA:           o_rdata <= {24'h00_0000, rx_q};
            `REG_IRQ_STATUS:     o_rdata <= {28'h000_0000, ist_q};
            `REG_IRQ_ENABLE:     o_rdata <= {28'h000_0000, ien_q};
            default: begin
               o_rdata <= 32'h0000_0000;
               o_rresp <= `RESP_SLVERR;
            end
         endcase
      end else if (o_rvalid && i_rready) begin
         o_rvalid <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // checks
   sequence s_rx_ack_slot;
      scl_fall && cnt_q == 4'h8 && !in_ack_q && st_q == ST_DATA && !ctl_q.direction_select;
   endsequence
   sequence s_tx_ack_end;
      scl_fall && in_ack_q && st_q == ST_DATA && ctl_q.direction_select;
   endsequence

   a_ack_level_drive: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
      s_rx_ack_slot |=> o_sda_oe_n == $past(ctl_q.ack_output_level)) else $error("ack level not driven");
   a_nack_sets_flag: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
      (ninth_tx && sda_q) |=> ctl_q.received_ack_flag) else $error("no-ack not recorded");
   a_ack_clears_flag: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
      (ninth_tx && !sda_q) |=> !ctl_q.received_ack_flag) else $error("ack not recorded");
   a_tx_keeps_going: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
      (s_tx_ack_end ##0 !ctl_q.received_ack_flag) |=> st_q == ST_DATA && o_sda_oe_n == tx_q[7])
      else $error("next byte not sent");
   a_tx_release_nack: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
      (s_tx_ack_end ##0 ctl_q.received_ack_flag) |=> o_sda_oe_n && st_q == ST_SKIP)
      else $error("sda not released");
   a_hit_raises_irq: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
      (addr_last && addr_match && ien_q[`IRQ_ADDR_HIT]) |=> ctl_q.address_hit_flag && o_irq)
      else $error("address hit missed");
   a_start_busy: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
      start |=> ctl_q.line_occupied_flag ##1 st_q == ST_ADDR) else $error("busy not set");
   a_dir_capture: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
      addr_last |=> ctl_q.master_direction_flag == $past(sda_q)) else $error("direction not captured");
   a_byte_done_set: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
      (scl_rise && cnt_q == 4'h7 && st_q != ST_IDLE && st_q != ST_SKIP) |=> ctl_q.byte_done_flag)
      else $error("byte done not set");
endmodule
`default_nettype wire

//--- i2c_master_model.sv
// i2c bus master model: drives scl, pulls sda low through o_sda_low
// assumes the bench resolves sda from every pull-down with a pull-up, and hands in the system clock
`timescale 1ns/1ps
`default_nettype none
module i2c_master_model (
   input  wire logic i_clk,
   output logic      o_scl,
   output logic      o_sda_low,
   input  wire logic i_sda
);
   // 8 system clocks per bit (160 ns): 5 low, 3 high; pins move by non-blocking
   // assignment just after a rising edge, so the slave's flops never race them.
   // data moves 2 clocks into the low phase; the slave's own change lands about
   // 4 clocks after the fall, still one clock ahead of the rise
   localparam int N_SET  = 2;
   localparam int N_LOW  = 5;
   localparam int N_HIGH = 3;
   initial begin
      o_scl     = 1'b1;
      o_sda_low = 1'b0;
   end
   // start: sda falls while scl is high
   task automatic start();
      @(posedge i_clk);
      o_sda_low <= 1'b1;
      repeat (N_HIGH) @(posedge i_clk);
      o_scl <= 1'b0;
   endtask
   // one clock; drv high releases sda, sample at the end of the high phase
   task automatic bitx(input logic drv, output logic smp);
      repeat (N_SET) @(posedge i_clk);
      o_sda_low <= ~drv;
      repeat (N_LOW - N_SET) @(posedge i_clk);
      o_scl <= 1'b1;
      repeat (N_HIGH) @(posedge i_clk);
      smp = i_sda;
      o_scl <= 1'b0;
   endtask
   // stop: sda rises while scl is high, freeing the bus
   task automatic stop();
      repeat (N_SET) @(posedge i_clk);
      o_sda_low <= 1'b1;
      repeat (N_LOW - N_SET) @(posedge i_clk);
      o_scl <= 1'b1;
      repeat (N_HIGH) @(posedge i_clk);
      o_sda_low <= 1'b0;
      repeat (N_HIGH) @(posedge i_clk);
   endtask
endmodule
`default_nettype wire

//--- test_i2c_slave_status_ack_control.sv
// bench for the i2c slave status block: axi4-lite host and an i2c master model
// assumes the block's own assertions sit in its design files
`timescale 1ns/1ps
`default_nettype none
`include "i2c_slv_regs.svh"
module test_i2c_slave_status_ack_control;
   logic        clk, rst_n, awvalid, wvalid, bready, arvalid, rready, s;
   logic        awready, wready, bvalid, arready, rvalid, sda_o, oe_n, irq, wake, scl, m_low;
   logic [7:0]  awaddr, araddr, rx, adr, d2, d3;
   logic [31:0] wdata, rdata, rd_v;
   logic [3:0]  wstrb;
   logic [1:0]  bresp, rresp, resp;
   int          error_cnt, n_tests;
   wire logic   sda;
   // open-drain line with pull-up: low if either party pulls
   assign sda = ~m_low & (oe_n | sda_o);
   i2c_slv_status dut (.i_sys_clk(clk), .i_reset_n(rst_n), .i_scl(scl), .i_sda(sda), .o_sda(sda_o),
      .o_sda_oe_n(oe_n), .o_irq(irq), .o_wake(wake), .i_awaddr(awaddr), .i_awvalid(awvalid),
      .o_awready(awready), .i_wdata(wdata), .i_wstrb(wstrb), .i_wvalid(wvalid), .o_wready(wready),
      .o_bresp(bresp), .o_bvalid(bvalid), .i_bready(bready), .i_araddr(araddr), .i_arvalid(arvalid),
      .o_arready(arready), .o_rdata(rdata), .o_rresp(rresp), .o_rvalid(rvalid), .i_rready(rready));
   i2c_master_model m (.i_clk(clk), .o_scl(scl), .o_sda_low(m_low), .i_sda(sda));
   always #10 clk = ~clk;
   ////////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      n_tests++;
      if (g !== e) begin
         error_cnt++;
         $display("BAD t=%0t got %h want %h", $time, g, e);
      end
   endtask
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", n_tests, error_cnt);
      if (error_cnt == 0 && n_tests > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   // write: address and data offered together, bready held until the answer
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      awaddr  <= a;
      wdata   <= d;
      wstrb   <= 4'h1;
      awvalid <= 1'b1;
      wvalid  <= 1'b1;
      bready  <= 1'b1;
      for (int n = 0; n < 40; n++) begin
         @(posedge clk);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
         if (bvalid) begin
            resp = bresp;
            bready <= 1'b0;
            return;
         end
      end
      error_cnt++;
      wrap_up();
   endtask
   task automatic rd(input logic [7:0] a);
      @(posedge clk);
      araddr  <= a;
      arvalid <= 1'b1;
      rready  <= 1'b1;
      for (int n = 0; n < 40; n++) begin
         @(posedge clk);
         if (arvalid && arready) arvalid <= 1'b0;
         if (rvalid) begin
            rd_v = rdata;
            resp = rresp;
            rready <= 1'b0;
            return;
         end
      end
      error_cnt++;
      wrap_up();
   endtask
   task automatic cbit(input int b, input logic e);
      rd(`REG_STATUS_CONTROL);
      chk(32'(rd_v[b]), 32'(e));
   endtask
   // k bits msb first from d; what the line shows shifts into rx
   task automatic bits(input int k, input logic [7:0] d);
      for (int i = 0; i < k; i++) begin
         m.bitx(d[7-i], s);
         rx = {rx[6:0], s};
      end
   endtask
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      {clk, rst_n, awvalid, wvalid, bready, arvalid, rready} = 7'h00;
      {awaddr, araddr, wdata, wstrb} = 52'h0;
      void'($urandom(47034));
      adr = 8'($urandom_range(8, 119));
      d2  = 8'($urandom);
      d3  = 8'($urandom);
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      rd(`REG_STATUS_CONTROL);
      chk(rd_v, 32'h0000_0081);
      rd(8'h1C);
      chk(32'(resp), 32'(`RESP_SLVERR));
      wr(8'h1C, 32'h0000_00FF);
      chk(32'(resp), 32'(`RESP_SLVERR));
      wr(`REG_SLAVE_ADDR, {24'h0, adr[6:0], 1'b0});
      chk(32'(resp), 32'(`RESP_OKAY));
      wr(`REG_IRQ_ENABLE, 32'h0000_0001);
      wr(`REG_STATUS_CONTROL, 32'h0000_0002);
      // foreign address: busy, but no hit and no acknowledge
      m.start();
      cbit(5, 1'b1);
      bits(8, {adr[6:0] ^ 7'h01, 1'b0});
      m.bitx(1'b1, s);
      chk(32'(s), 32'h1);
      cbit(6, 1'b0);
      chk(32'(irq), 32'h0);
      m.stop();
      // own address, master writes: one byte acknowledged, next refused
      m.start();
      bits(8, {adr[6:0], 1'b0});
      cbit(6, 1'b1);
      cbit(2, 1'b0);
      chk(32'({irq, wake}), 32'h3);
      wr(`REG_STATUS_CONTROL, 32'h0000_0002);
      m.bitx(1'b1, s);
      chk(32'(s), 32'h0);
      bits(4, d2);
      cbit(7, 1'b0);
      bits(4, d2 << 4);
      m.bitx(1'b1, s);
      chk(32'(s), 32'h0);
      rd(`REG_DATA);
      chk(rd_v, {24'h0, d2});
      cbit(7, 1'b1);
      wr(`REG_STATUS_CONTROL, 32'h0000_000A);
      bits(8, d3);
      m.bitx(1'b1, s);
      chk(32'(s), 32'h1);
      m.stop();
      rd(`REG_IRQ_STATUS);
      chk(32'(rd_v[1]), 32'h1);
      wr(`REG_IRQ_CLEAR, 32'h0000_000F);
      rd(`REG_IRQ_STATUS);
      chk(32'({rd_v[3:0], irq}), 32'h0);
      // own address, master reads with the interrupt masked: ack, then nack
      wr(`REG_IRQ_ENABLE, 32'h0000_0000);
      m.start();
      bits(8, {adr[6:0], 1'b1});
      cbit(2, 1'b1);
      rd(`REG_IRQ_STATUS);
      chk(32'({rd_v[0], irq}), 32'h2);
      wr(`REG_STATUS_CONTROL, 32'h0000_0012);
      wr(`REG_DATA, {24'h0, d2});
      m.bitx(1'b1, s);
      chk(32'(s), 32'h0);
      bits(8, 8'hFF);
      chk({24'h0, rx}, {24'h0, d2});
      wr(`REG_DATA, {24'h0, d3});
      m.bitx(1'b0, s);
      cbit(0, 1'b0);
      bits(8, 8'hFF);
      chk({24'h0, rx}, {24'h0, d3});
      m.bitx(1'b1, s);
      cbit(0, 1'b1);
      bits(8, 8'hFF);
      chk({24'h0, rx}, 32'h0000_00FF);
      m.stop();
      wrap_up();
   end
endmodule
`default_nettype wire
